// ### bench/gtli_chk.sv
/*
  Checker of the bus interface top: handshake order, roles, requests.
  Assumes it is bound to gtli_top and sees only its ports.
*/
`default_nettype none

module gtli_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] dio_out,
  input wire logic dio_oe,
  input wire logic dav_in,
  input wire logic dav_oe,
  input wire logic nrfd_in,
  input wire logic nrfd_oe,
  input wire logic ndac_in,
  input wire logic ndac_oe,
  input wire logic atn_in,
  input wire logic ifc_in,
  input wire logic srq_oe,
  input wire logic srq_enable,
  input wire logic ev_limit,
  input wire logic ev_syntax,
  input wire logic ev_set_done,
  input wire logic ev_scan_done,
  input wire logic rx_valid,
  input wire logic talker,
  input wire logic listener,
  input wire logic listen_only
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ****
  // Relations
  // ****
  chk_roles_apart: assert property (!(talker && listener))
    else $error("talker and listener together");
  chk_lon_silent: assert property (listen_only |-> !talker && !dio_oe)
    else $error("talking in listen-only");
  chk_data_owner: assert property (dio_oe |-> talker)
    else $error("data lines driven while not talker");
  chk_acp_take: assert property (ndac_oe && !nrfd_oe && dav_in |=> nrfd_oe && !ndac_oe)
    else $error("byte not taken");
  chk_acp_hold: assert property (nrfd_oe && dav_in |=> nrfd_oe)
    else $error("not ready dropped early");
  chk_rx_pulse: assert property (rx_valid |-> !$past(atn_in) ##1 !rx_valid)
    else $error("bad receive pulse");
  chk_dav_ready: assert property ($rose(dav_oe) |-> !$past(nrfd_in))
    else $error("valid raised while not ready");
  chk_dav_hold: assert property (dav_oe && ndac_in && !atn_in && !ifc_in |=> dav_oe && dio_oe)
    else $error("valid dropped before accept");
  chk_data_still: assert property (dav_oe && $past(dav_oe) |-> $stable(dio_out))
    else $error("data moved under valid");
  chk_atn_free: assert property (atn_in || ifc_in |=> !dav_oe && !dio_oe)
    else $error("drivers kept under attention");
  chk_srq_raise: assert property ((ev_limit || ev_syntax || ev_set_done || ev_scan_done)
    && srq_enable |-> ##[1:2] srq_oe)
    else $error("service request not raised");
endmodule : gtli_chk

bind gtli_top gtli_chk i_gtli_chk (.*);

`default_nettype wire

// ### bench/gtli_ctl.sv
/*
  Bus controller model: source for commands and data, acceptor for
  talker bytes. Assumes the bench ORs its lines with the design's.
*/
`default_nettype none

module gtli_ctl (
  input wire logic clk,
  input wire logic dav_in,
  input wire logic nrfd_in,
  input wire logic ndac_in,
  input wire logic eoi_in,
  input wire logic [7:0] dio_in,
  output var logic atn_in,
  output var logic [7:0] c_dio,
  output var logic c_dav,
  output var logic c_nrfd,
  output var logic c_ndac,
  output var logic c_eoi,
  output var logic hang
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Handshake
  // ****
  initial begin
    {atn_in, c_dio, c_dav, c_nrfd, c_ndac, c_eoi, hang} = '0;
  end

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : tk

  function automatic logic ln(input int k);
    return k == 0 ? nrfd_in : (k == 1 ? ndac_in : dav_in);
  endfunction : ln

  // Bounded so a dead handshake ends the run
  task automatic await(input int k, input logic v);
    for (int i = 0; i < 400 && ln(k) !== v; i++) tk(1);
    if (ln(k) !== v) hang = 1'b1;
  endtask : await

  task automatic send(input logic [7:0] b, input logic a, input logic e);
    atn_in = a;
    c_dio = b;
    c_eoi = e;
    tk(3);
    await(0, 1'b0);
    c_dav = 1'b1;
    await(1, 1'b0);
    c_dav = 1'b0;
    c_dio = 8'h00;
    c_eoi = 1'b0;
    tk(1);
  endtask : send

  task automatic recv(output logic [7:0] b, output logic e);
    atn_in = 1'b0;
    c_ndac = 1'b1;
    await(2, 1'b1);
    b = dio_in;
    e = eoi_in;
    c_nrfd = 1'b1;
    c_ndac = 1'b0;
    await(2, 1'b0);
    c_nrfd = 1'b0;
  endtask : recv
endmodule : gtli_ctl

`default_nettype wire

// ### bench/gtli_top_tb.sv
/*
  Bench of the bus interface top with a controller model on the bus.
  Assumes the checker binds itself; listen-only delay shortened.
*/
`default_nettype none

module gtli_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LON = 50;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] dio_in, dio_out, rx_data, c_dio, rx_q;
  logic [7:0] status_in = 8'h81;
  logic [7:0] tx_data = 8'h00;
  logic [6:0] backup_addr = 7'h05;
  logic [6:0] addr_val = 7'h00;
  logic [3:0] ev = 4'h0;
  logic dav_in, nrfd_in, ndac_in, eoi_in, atn_in, c_dav, c_nrfd, c_ndac, c_eoi, hang;
  logic dav_out, dav_oe, nrfd_out, nrfd_oe, ndac_out, ndac_oe, eoi_out, eoi_oe;
  logic srq_out, srq_oe, dio_oe, tx_ready, rx_end, rx_valid, talker, listener;
  logic remote, listen_only, lon_shown, poll_mode, dev_clear, dev_trigger, rx_e;
  logic ev_limit, ev_syntax, ev_set_done, ev_scan_done;
  logic ifc_in = 1'b0;
  logic ren_in = 1'b0;
  logic addr_load = 1'b0;
  logic local_req = 1'b0;
  logic srq_enable = 1'b0;
  logic tx_end = 1'b0;
  logic tx_valid = 1'b0;
  int n_errors = 0;
  int compares = 0;
  int n_rx = 0;
  int n_clr = 0;
  int n_trg = 0;

  always #50 clk = ~clk;
  // ****
  // Bus wiring: pulled-up lines read false when released
  // ****
  assign dav_in = c_dav | dav_oe;
  assign nrfd_in = c_nrfd | nrfd_oe;
  assign ndac_in = c_ndac | ndac_oe;
  assign eoi_in = c_eoi | eoi_oe;
  assign dio_in = c_dio | (dio_out & {8{dio_oe}});
  assign {ev_limit, ev_syntax, ev_set_done, ev_scan_done} = ev;

  gtli_top #(.LON_SHOW_CYC(LON)) i_gtli_top (.*);
  gtli_ctl i_gtli_ctl (.*);

  always @(posedge clk) begin
    if (rx_valid === 1'b1) begin
      rx_q <= rx_data;
      rx_e <= rx_end;
      n_rx <= n_rx + 1;
    end
    if (dev_clear === 1'b1) n_clr <= n_clr + 1;
    if (dev_trigger === 1'b1) n_trg <= n_trg + 1;
  end

  always @(posedge hang) begin
    n_errors++;
    conclude();
  end
  // ****
  // Helpers
  // ****
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : tk

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cmd(input logic [7:0] b);
    i_gtli_ctl.send(b, 1'b1, 1'b0);
    tk(2);
  endtask : cmd

  task automatic put(input logic [7:0] b);
    int i;
    tx_data = b;
    tx_end = 1'b1;
    tx_valid = 1'b1;
    for (i = 0; i < 200 && tx_ready !== 1'b1; i++) tk(1);
    if (tx_ready !== 1'b1) begin
      n_errors++;
      conclude();
    end
    tk(1);
    tx_valid = 1'b0;
  endtask : put

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  // ****
  // Scenarios
  // ****
  task automatic t_listen();
    ren_in = 1'b1;
    cmd(8'h25);
    chk("listener", listener, 8'h01);
    chk("remote", remote, 8'h01);
    i_gtli_ctl.send(8'h41, 1'b0, 1'b1);
    tk(1);
    chk("rx", rx_q, 8'h41);
    chk("rx_end", rx_e, 8'h01);
    local_req = 1'b1;
    tk(1);
    local_req = 1'b0;
    tk(2);
    chk("local", remote, 8'h00);
    cmd(8'h3F);
    chk("unlisten", listener, 8'h00);
    $display("t_listen done");
  endtask : t_listen

  task automatic t_trig();
    cmd(8'h25);
    cmd(8'h08);
    chk("trigger", n_trg[7:0], 8'h01);
    chk("remote again", remote, 8'h01);
    cmd(8'h04);
    chk("sdc", n_clr[7:0], 8'h01);
    cmd(8'h01);
    chk("go to local", remote, 8'h00);
    $display("t_trig done");
  endtask : t_trig

  task automatic t_talk();
    logic [7:0] b;
    logic e;
    cmd(8'h45);
    chk("talk drops listen", listener, 8'h00);
    cmd(8'h25);
    chk("listen drops talk", talker, 8'h00);
    cmd(8'h45);
    fork
      i_gtli_ctl.recv(b, e);
      put(8'hA5);
    join
    chk("tx byte", b, 8'hA5);
    chk("tx end", e, 8'h01);
    ifc_in = 1'b1;
    tk(1);
    ifc_in = 1'b0;
    tk(2);
    chk("ifc", talker, 8'h00);
    $display("t_talk done");
  endtask : t_talk

  task automatic t_srq();
    logic [7:0] b;
    logic e;
    srq_enable = 1'b1;
    for (int i = 0; i < 4; i++) begin
      ev[i] = 1'b1;
      tk(1);
      ev = 4'h0;
      tk(2);
      chk("srq", srq_oe, 8'h01);
      chk("srq level", srq_out, 8'h01);
      cmd(8'h14);
      chk("dcl srq", srq_oe, 8'h00);
    end
    chk("dcl", n_clr[7:0], 8'h05);
    ev = 4'h8;
    tk(1);
    ev = 4'h0;
    cmd(8'h18);
    chk("poll on", poll_mode, 8'h01);
    cmd(8'h45);
    i_gtli_ctl.recv(b, e);
    tk(2);
    chk("status", b, 8'hC1);
    chk("srq polled", srq_oe, 8'h00);
    cmd(8'h19);
    chk("poll off", poll_mode, 8'h00);
    cmd(8'h5F);
    chk("untalk", talker, 8'h00);
    $display("t_srq done");
  endtask : t_srq

  task automatic t_lon();
    int n;
    addr_val = 7'h1E;
    addr_load = 1'b1;
    tk(1);
    addr_load = 1'b0;
    cmd(8'h3E);
    chk("addr 30", listener, 8'h01);
    cmd(8'h3F);
    addr_val = 7'h1F;
    addr_load = 1'b1;
    tk(1);
    addr_load = 1'b0;
    for (n = 0; n < 200 && lon_shown !== 1'b1; n++) tk(1);
    chk("lon", listen_only, 8'h01);
    chk("lon delay", 8'((n >= LON - 2) && (n <= LON + 2)), 8'h01);
    // Controller idle; the model acts as the only-mode talker
    i_gtli_ctl.send(8'h5A, 1'b0, 1'b0);
    tk(1);
    chk("lon rx", rx_q, 8'h5A);
    $display("t_lon done");
  endtask : t_lon

  initial begin
    tk(5);
    reset_n = 1'b1;
    tk(6);
    t_listen();
    t_trig();
    t_talk();
    t_srq();
    t_lon();
    conclude();
  end
endmodule : gtli_top_tb

`default_nettype wire

// ### rtl/gtli_pkg.sv
/*
  Shared constants and types of the instrument-side bus interface:
  command codes, timing counts, handshake state encodings.
  Assumes a single 10 MHz clock for all logic.
*/
`default_nettype none

package gtli_pkg;

  // ****************************************************
  // Clock and timing
  // ****************************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int SETTLE_NS = 2000;
  localparam int SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int LON_SHOW_MS = 700;
  localparam int LON_SHOW_CYC = LON_SHOW_MS * (CLK_HZ / 1000);
  localparam int LON_CNT_W = 23;

  // ****************************************************
  // Addresses and command codes (7 bits, ATN true)
  // ****************************************************
  localparam logic [6:0] ADDR_MAX = 7'h1E;
  localparam logic [4:0] ADDR_NONE = 5'h1F;
  localparam logic [4:0] ADDR_RESET = 5'h00;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam int RQS_BIT = 6;

  // ****************************************************
  // Handshake states
  // ****************************************************
  typedef enum logic [2:0] {
    SRC_IDLE = 3'b001,
    SRC_SETL = 3'b010,
    SRC_DAV = 3'b100
  } gtli_src_t;

  typedef enum logic [2:0] {
    ACP_IDLE = 3'b001,
    ACP_RDY = 3'b010,
    ACP_ACC = 3'b100
  } gtli_acp_t;

endpackage : gtli_pkg

`default_nettype wire

// ### rtl/gtli_timer.sv
/*
  One-shot down counter: a start pulse loads the count, a done pulse
  follows when it runs out. Cancel stops it without a done.
  Assumes asynchronous active-low reset from the top.
*/
`default_nettype none

module gtli_timer #(
  parameter int W = 23,
  parameter int CYCLES = 7_000_000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic cancel,
  output logic done
);

  typedef struct packed {
    logic run;
    logic [W-1:0] cnt;
    logic done;
  } gtli_tmr_t;

  gtli_tmr_t st_ff;
  gtli_tmr_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (start) begin
      nxt_st.run = 1'b1;
      nxt_st.cnt = W'(CYCLES - 1);
    end else if (cancel) begin
      nxt_st.run = 1'b0;
    end else if (st_ff.run) begin
      if (st_ff.cnt == '0) begin
        nxt_st.run = 1'b0;
        nxt_st.done = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done = st_ff.done;

endmodule : gtli_timer

`default_nettype wire

// ### rtl/gtli_top.sv
/*
  Instrument-side talker/listener bus interface: source and acceptor
  handshakes, addressing, serial poll, service request, remote/local,
  device clear and trigger, listen-only mode.
  Assumes bus lines are seen in logical sense (1 = true) and that an
  outside transceiver turns each _oe into an open-collector pull-down.
*/
`default_nettype none

// Notes on behaviour
// - Talker places bytes with the three-wire handshake DAV/NRFD/NDAC.
// - Acceptor drives NRFD and NDAC for each byte, commands included.
// - Talker answers serial polls with status; listen addressing drops talk.
// - Listener, with listen-only mode; talk addressing drops listen.
// - Asserts SRQ for service, releases it once polled.
// - Remote/local follows REN and addressing; no local lockout.
// - Never answers a parallel poll; identify drives no data line.
// - Universal and selected device clear both give a clear action.
// - Group trigger while listener starts the trigger action.
// - No controller: ATN, IFC and REN are never driven.
// - Local primary address 0 to 30 compared against address commands.
// - Address value 31 or above selects listen-only mode.
// - Listen-only indication appears about 700 ms after entry.
// - Listen-only accepts all data, performs no talking.
// - Listen command for address n is space plus n.
// - Controller taking the bus pauses a transfer, which resumes later.
// - After power returns, settings reload from backup memory.
// - Service requested on limit, syntax error, setting and scan done.
module gtli_top #(
  parameter int LON_SHOW_CYC = gtli_pkg::LON_SHOW_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] dio_in,
  output logic [7:0] dio_out,
  output logic dio_oe,
  input wire logic dav_in,
  output logic dav_out,
  output logic dav_oe,
  input wire logic nrfd_in,
  output logic nrfd_out,
  output logic nrfd_oe,
  input wire logic ndac_in,
  output logic ndac_out,
  output logic ndac_oe,
  input wire logic eoi_in,
  output logic eoi_out,
  output logic eoi_oe,
  output logic srq_out,
  output logic srq_oe,
  input wire logic atn_in,
  input wire logic ifc_in,
  input wire logic ren_in,
  input wire logic [6:0] backup_addr,
  input wire logic [6:0] addr_val,
  input wire logic addr_load,
  input wire logic local_req,
  input wire logic srq_enable,
  input wire logic ev_limit,
  input wire logic ev_syntax,
  input wire logic ev_set_done,
  input wire logic ev_scan_done,
  input wire logic [7:0] status_in,
  input wire logic [7:0] tx_data,
  input wire logic tx_end,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic rx_valid,
  output logic talker,
  output logic listener,
  output logic remote,
  output logic listen_only,
  output logic lon_shown,
  output logic poll_mode,
  output logic dev_clear,
  output logic dev_trigger
);

  // ****************************************************
  // Reset release
  // ****************************************************
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    gtli_pkg::gtli_src_t src;
    gtli_pkg::gtli_acp_t acp;
    logic loaded;
    logic [4:0] addr;
    logic lon;
    logic lon_shown;
    logic talk;
    logic lstn;
    logic spe;
    logic rem;
    logic rqs;
    logic pend;
    logic poll_byte;
    logic [4:0] settle;
    logic [7:0] dio;
    logic dio_oe;
    logic eoi_oe;
    logic dav_oe;
    logic nrfd_oe;
    logic ndac_oe;
    logic tx_ready;
    logic [7:0] rx_data;
    logic rx_end;
    logic rx_valid;
    logic dev_clear;
    logic dev_trigger;
  } gtli_state_t;

  gtli_state_t st_ff;
  gtli_state_t nxt_st;

  logic lon_start;
  logic lon_cancel;
  logic lon_done;

  gtli_timer #(
    .W(gtli_pkg::LON_CNT_W),
    .CYCLES(LON_SHOW_CYC)
  ) u_lon_timer (
    .clk(clk),
    .rst_n(rst_sync_ff),
    .start(lon_start),
    .cancel(lon_cancel),
    .done(lon_done)
  );

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    logic [6:0] cmd;
    logic [6:0] new_addr;
    logic new_load;
    logic talk_act;
    logic acp_act;
    logic take;
    logic set_rqs;
    cmd = dio_in[6:0];
    new_addr = addr_val;
    new_load = addr_load;
    talk_act = 1'b0;
    acp_act = 1'b0;
    take = 1'b0;
    set_rqs = 1'b0;
    nxt_st = st_ff;
    nxt_st.rx_valid = 1'b0;
    nxt_st.dev_clear = 1'b0;
    nxt_st.dev_trigger = 1'b0;
    lon_start = 1'b0;
    lon_cancel = 1'b0;

    // Backup value is taken once, on the first cycle after release
    if (!st_ff.loaded) begin
      nxt_st.loaded = 1'b1;
      new_addr = backup_addr;
      new_load = 1'b1;
    end

    if (new_load) begin
      if (new_addr > gtli_pkg::ADDR_MAX) begin
        nxt_st.lon = 1'b1;
        nxt_st.talk = 1'b0;
        nxt_st.lstn = 1'b1;
        lon_start = !st_ff.lon;
      end else begin
        nxt_st.addr = new_addr[4:0];
        nxt_st.lon = 1'b0;
        nxt_st.lon_shown = 1'b0;
        lon_cancel = 1'b1;
        if (st_ff.lon) begin
          nxt_st.lstn = 1'b0;
        end
      end
    end
    if (lon_done) begin
      nxt_st.lon_shown = 1'b1;
    end

    // ----------------------------------------------------
    // Acceptor handshake
    // ----------------------------------------------------
    acp_act = atn_in | st_ff.lstn | st_ff.lon;
    unique case (st_ff.acp)
      gtli_pkg::ACP_IDLE: begin
        nxt_st.nrfd_oe = 1'b0;
        nxt_st.ndac_oe = 1'b0;
        if (acp_act) begin
          nxt_st.ndac_oe = 1'b1;
          nxt_st.acp = gtli_pkg::ACP_RDY;
        end
      end
      gtli_pkg::ACP_RDY: begin
        if (!acp_act) begin
          nxt_st.ndac_oe = 1'b0;
          nxt_st.acp = gtli_pkg::ACP_IDLE;
        end else if (dav_in) begin
          nxt_st.nrfd_oe = 1'b1;
          nxt_st.ndac_oe = 1'b0;
          nxt_st.acp = gtli_pkg::ACP_ACC;
          if (atn_in) begin
            // Address groups use the low five bits for the device number
            if (cmd[6:5] == gtli_pkg::GRP_LISTEN) begin
              if (cmd[4:0] == gtli_pkg::ADDR_NONE) begin
                nxt_st.lstn = st_ff.lon;
              end else if (cmd[4:0] == st_ff.addr && !st_ff.lon) begin
                nxt_st.lstn = 1'b1;
                nxt_st.talk = 1'b0;
                if (ren_in) begin
                  nxt_st.rem = 1'b1;
                end
              end
            end else if (cmd[6:5] == gtli_pkg::GRP_TALK) begin
              if (cmd[4:0] == st_ff.addr && cmd[4:0] != gtli_pkg::ADDR_NONE
                  && !st_ff.lon) begin
                nxt_st.talk = 1'b1;
                nxt_st.lstn = 1'b0;
              end else begin
                nxt_st.talk = 1'b0;
              end
            end else if (cmd == gtli_pkg::CMD_DCL
                         || (cmd == gtli_pkg::CMD_SDC && st_ff.lstn)) begin
              nxt_st.dev_clear = 1'b1;
              nxt_st.rqs = 1'b0;
            end else if (cmd == gtli_pkg::CMD_GET && st_ff.lstn) begin
              nxt_st.dev_trigger = 1'b1;
              nxt_st.rqs = 1'b0;
            end else if (cmd == gtli_pkg::CMD_GTL && st_ff.lstn) begin
              nxt_st.rem = 1'b0;
            end else if (cmd == gtli_pkg::CMD_SPE) begin
              nxt_st.spe = 1'b1;
            end else if (cmd == gtli_pkg::CMD_SPD) begin
              nxt_st.spe = 1'b0;
            end
          end else if (st_ff.lstn || st_ff.lon) begin
            nxt_st.rx_data = dio_in;
            nxt_st.rx_end = eoi_in;
            nxt_st.rx_valid = 1'b1;
          end
        end
      end
      gtli_pkg::ACP_ACC: begin
        if (!dav_in) begin
          nxt_st.nrfd_oe = 1'b0;
          nxt_st.ndac_oe = acp_act;
          nxt_st.acp = acp_act ? gtli_pkg::ACP_RDY : gtli_pkg::ACP_IDLE;
        end
      end
      default: begin
        nxt_st.acp = gtli_pkg::ACP_IDLE;
      end
    endcase

    // Local key and REN; there is no lockout state to block the key
    if (!ren_in || local_req) begin
      nxt_st.rem = 1'b0;
    end
    if (ifc_in) begin
      nxt_st.talk = 1'b0;
      nxt_st.lstn = st_ff.lon;
      nxt_st.spe = 1'b0;
    end

    // ----------------------------------------------------
    // Source handshake; ATN, or EOI with ATN, stops all driving
    // ----------------------------------------------------
    talk_act = st_ff.talk && !st_ff.lon && !atn_in && !ifc_in;
    take = tx_valid && st_ff.tx_ready && talk_act && !st_ff.spe;
    nxt_st.tx_ready = 1'b0;
    unique case (st_ff.src)
      gtli_pkg::SRC_IDLE: begin
        nxt_st.dio_oe = 1'b0;
        nxt_st.eoi_oe = 1'b0;
        nxt_st.dav_oe = 1'b0;
        if (talk_act && st_ff.spe) begin
          nxt_st.dio = status_in;
          nxt_st.dio[gtli_pkg::RQS_BIT] = st_ff.rqs;
          nxt_st.poll_byte = 1'b1;
          nxt_st.settle = 5'(gtli_pkg::SETTLE_CYC);
          nxt_st.src = gtli_pkg::SRC_SETL;
        end else if (talk_act && st_ff.pend) begin
          nxt_st.settle = 5'(gtli_pkg::SETTLE_CYC);
          nxt_st.src = gtli_pkg::SRC_SETL;
        end else if (take) begin
          nxt_st.dio = tx_data;
          nxt_st.pend = 1'b1;
          nxt_st.poll_byte = 1'b0;
          nxt_st.eoi_oe = 1'b0;
          nxt_st.settle = 5'(gtli_pkg::SETTLE_CYC);
          nxt_st.src = gtli_pkg::SRC_SETL;
        end else begin
          nxt_st.tx_ready = talk_act && !st_ff.spe;
        end
      end
      gtli_pkg::SRC_SETL: begin
        nxt_st.dio_oe = 1'b1;
        nxt_st.eoi_oe = st_ff.pend && !st_ff.poll_byte && tx_end;
        if (st_ff.settle != '0) begin
          nxt_st.settle = st_ff.settle - 1'b1;
        end else if (!nrfd_in) begin
          nxt_st.dav_oe = 1'b1;
          nxt_st.src = gtli_pkg::SRC_DAV;
        end
      end
      gtli_pkg::SRC_DAV: begin
        if (!ndac_in) begin
          nxt_st.dav_oe = 1'b0;
          nxt_st.dio_oe = 1'b0;
          nxt_st.eoi_oe = 1'b0;
          nxt_st.pend = 1'b0;
          nxt_st.src = gtli_pkg::SRC_IDLE;
          if (st_ff.poll_byte) begin
            nxt_st.rqs = 1'b0;
          end
        end
      end
      default: begin
        nxt_st.src = gtli_pkg::SRC_IDLE;
      end
    endcase
    // Held byte stays pending and is sent again once ATN falls
    if (!talk_act && st_ff.src != gtli_pkg::SRC_IDLE) begin
      nxt_st.dav_oe = 1'b0;
      nxt_st.dio_oe = 1'b0;
      nxt_st.eoi_oe = 1'b0;
      nxt_st.src = gtli_pkg::SRC_IDLE;
    end
    if (!st_ff.talk || st_ff.lon || ifc_in) begin
      nxt_st.pend = 1'b0;
    end

    // Service request; a new event wins over a clear in the same cycle
    set_rqs = srq_enable && (ev_limit || ev_syntax || ev_set_done || ev_scan_done);
    if (set_rqs) begin
      nxt_st.rqs = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      st_ff <= '{
        src: gtli_pkg::SRC_IDLE,
        acp: gtli_pkg::ACP_IDLE,
        addr: gtli_pkg::ADDR_RESET,
        settle: 5'h00,
        dio: 8'h00,
        rx_data: 8'h00,
        default: 1'b0
      };
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************
  // Outputs; ATN, IFC and REN have no drivers here
  // ****************************************************
  assign dio_out = st_ff.dio;
  assign dio_oe = st_ff.dio_oe;
  assign dav_out = st_ff.dav_oe;
  assign dav_oe = st_ff.dav_oe;
  assign nrfd_out = st_ff.nrfd_oe;
  assign nrfd_oe = st_ff.nrfd_oe;
  assign ndac_out = st_ff.ndac_oe;
  assign ndac_oe = st_ff.ndac_oe;
  assign eoi_out = st_ff.eoi_oe;
  assign eoi_oe = st_ff.eoi_oe;
  assign srq_out = st_ff.rqs;
  assign srq_oe = st_ff.rqs;
  assign tx_ready = st_ff.tx_ready;
  assign rx_data = st_ff.rx_data;
  assign rx_end = st_ff.rx_end;
  assign rx_valid = st_ff.rx_valid;
  assign talker = st_ff.talk;
  assign listener = st_ff.lstn;
  assign remote = st_ff.rem;
  assign listen_only = st_ff.lon;
  assign lon_shown = st_ff.lon_shown;
  assign poll_mode = st_ff.spe;
  assign dev_clear = st_ff.dev_clear;
  assign dev_trigger = st_ff.dev_trigger;

endmodule : gtli_top

`default_nettype wire
